// *** sesb_line_if.sv ***
// sesb_line_if: synchronised bus line levels and events passed to the protocol engine.
// assumes both ends run on core_clk.
interface sesb_line_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sda;
	logic wp;

	modport src (output scl_rise, output scl_fall, output start, output stop,
		output sda, output wp);
	modport dst (input scl_rise, input scl_fall, input start, input stop,
		input sda, input wp);
endinterface : sesb_line_if

// *** sesb_line_sync.sv ***
// sesb_line_sync: two-stage synchronisers and edge/condition detection for the bus pins.
// assumes the bus clock is far slower than core_clk, so one cycle per event suffices.
module sesb_line_sync
	import sesb_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// pins
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	input  wire logic wp_pin,
	// events to the engine
	sesb_line_if.src  ln
);

	// ===========================================================
	// synchronisers: index 0 scl, 1 sda, 2 write inhibit
	logic [2:0] meta;
	logic [2:0] sync;
	logic [1:0] prev;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta <= 3'h3;
			sync <= 3'h3;
			prev <= 2'h3;
		end else begin
			meta <= {wp_pin, sda_pin, scl_pin};
			sync <= meta;
			prev <= sync[1:0];
		end
	end

	// ===========================================================
	// events, all from the second stage onward
	assign ln.scl_rise = sync[0] & ~prev[0];
	assign ln.scl_fall = ~sync[0] & prev[0];
	// data moving while the clock is high marks start or stop
	assign ln.start    = sync[0] & prev[0] & prev[1] & ~sync[1];
	assign ln.stop     = sync[0] & prev[0] & ~prev[1] & sync[1];
	assign ln.sda      = sync[1];
	assign ln.wp       = sync[2];

endmodule : sesb_line_sync

// *** sesb_master_model.sv ***
// sesb_master_model: behavioural bus master that drives the serial clock and pulls data low.
// assumes an 800 ns bit time built from core_clk falling edges; data line pulled up outside.
module sesb_master_model (
	// clock
	input  wire logic core_clk,
	// bus lines
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ns;

	// ===========================================================
	// bus line timing
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wt

	// also serves as repeated start: data is released before the clock rises
	task automatic start();
		sda_low = 1'b0;
		wt(2);
		scl = 1'b1;
		wt(4);
		sda_low = 1'b1;
		wt(4);
		scl = 1'b0;
		wt(2);
	endtask : start

	// data changes only while the clock is low and holds across the rise
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		wt(2);
		scl = 1'b1;
		wt(4);
		r   = sda_line;
		scl = 1'b0;
		wt(2);
	endtask : bit_io

	// eight bits msb first, then the acknowledge slot; ack_in high leaves the slot released
	task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(ack_in, ack_out);
	endtask : byte_io

	task automatic stop();
		sda_low = 1'b1;
		wt(2);
		scl = 1'b1;
		wt(4);
		sda_low = 1'b0;
		wt(4);
	endtask : stop
endmodule : sesb_master_model

// *** sesb_pkg.sv ***
// sesb_pkg: constants, timing counts and state type of the serial eeprom bus slave.
// assumes a 10 MHz core clock; the nonvolatile array sits outside the block.
package sesb_pkg;

	// ===========================================================
	// timing
	localparam int SESB_CLK_HZ        = 10_000_000;
	localparam int SESB_WRITE_TIME_MS = 10;
	// longest time, so the cycle count rounds down
	localparam int SESB_WRITE_CYCLES  = (SESB_WRITE_TIME_MS * SESB_CLK_HZ) / 1000;
	localparam int SESB_BUSY_CNT_W    = 17;

	// ===========================================================
	// select byte and address layout
	localparam logic [2:0]  SESB_CHIP_SEL    = 3'h0;
	localparam int          SESB_RW_BIT      = 0;
	localparam logic [2:0]  SESB_LAST_BIT    = 3'h7;
	localparam int          SESB_ADDR_W      = 15;
	localparam int          SESB_PAGE_W      = 6;
	localparam int          SESB_PAGE_BYTES  = 64;
	localparam logic [14:0] SESB_MASK_LARGE  = 15'h7fff;
	localparam logic [14:0] SESB_MASK_SMALL  = 15'h3fff;
	localparam logic [14:0] SESB_ADDR_RST    = 15'h0000;
	localparam logic [5:0]  SESB_PAGE_STEP   = 6'h01;
	localparam logic [14:0] SESB_ADDR_STEP   = 15'h0001;

	// ===========================================================
	// protocol states
	typedef enum logic [3:0] {
		S_IDLE, S_DEVSEL, S_DEV_ACK, S_ADDR_HI, S_HI_ACK, S_ADDR_LO, S_LO_ACK,
		S_WR_DATA, S_DATA_ACK, S_RD_DATA, S_RD_ACK, S_RD_NEXT, S_BUSY
	} sesb_state_e;

endpackage : sesb_pkg

// *** sesb_top.sv ***
// sesb_top: serial bus slave front end of a byte-wide eeprom with page latch and busy timer.
// assumes an external array with registered read (data within one cycle of the address)
// and a write strobe port; open-drain data pin resolved outside from sda_oe.
module sesb_top
	import sesb_pkg::*;
#(
	parameter int unsigned WRITE_TIME_CYCLES = SESB_WRITE_CYCLES,
	parameter bit          SMALL_VARIANT     = 1'b0,
	// type code value is arbitrary
	parameter logic [3:0]  DEV_TYPE_ID       = 4'h5
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// serial bus
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output wire logic                   sda_out,
	output wire logic                   sda_oe,
	input  wire logic                   write_inhibit_pin,
	// array read port
	output wire logic [SESB_ADDR_W-1:0] mem_rd_addr,
	input  wire logic [7:0]             mem_rd_data,
	// array write port
	output logic                        mem_wr_en,
	output logic [SESB_ADDR_W-1:0]      mem_wr_addr,
	output logic [7:0]                  mem_wr_data,
	// status
	output wire logic                   busy
);

	// ===========================================================
	// line synchroniser
	sesb_line_if ln ();

	sesb_line_sync u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.scl_pin  (scl_in),
		.sda_pin  (sda_in),
		.wp_pin   (write_inhibit_pin),
		.ln       (ln)
	);

	// ===========================================================
	// state and datapath
	sesb_state_e                state;
	sesb_state_e                next_state;
	logic [7:0]                 shreg;
	logic [2:0]                 bit_cnt;
	logic                       rx_full;
	logic                       oe;
	logic                       next_oe;
	logic                       rd_mode;
	logic                       wp;
	logic                       data_acked;
	logic [SESB_ADDR_W-1:0]     addr;
	logic [SESB_PAGE_BYTES-1:0] page_mask;
	logic [7:0]                 page_buf [SESB_PAGE_BYTES];
	logic [SESB_BUSY_CNT_W-1:0] busy_cnt;

	function automatic logic is_rx(input sesb_state_e s);
		return (s == S_DEVSEL) || (s == S_ADDR_HI) || (s == S_ADDR_LO) || (s == S_WR_DATA);
	endfunction : is_rx

	function automatic logic is_ack(input sesb_state_e s);
		return (s == S_DEV_ACK) || (s == S_HI_ACK) || (s == S_LO_ACK) || (s == S_DATA_ACK);
	endfunction : is_ack

	// ===========================================================
	// decode
	wire        busy_st   = (state == S_BUSY);
	// the data input is dead while programming
	wire        start_ev  = ln.start & ~busy_st;
	wire        stop_ev   = ln.stop & ~busy_st;
	wire        quiet     = ~start_ev & ~stop_ev;
	wire        fall      = ln.scl_fall;
	wire        rx_bit    = is_rx(state) & ln.scl_rise & ~rx_full;
	wire        rx_done   = is_rx(state) & fall & rx_full;
	wire        ack_end   = is_ack(state) & fall;
	// seven select bits, type code over chip select
	wire        dev_match = (shreg[7:1] == {DEV_TYPE_ID, SESB_CHIP_SEL});
	wire        load_rd   = fall & (((state == S_DEV_ACK) & rd_mode) | (state == S_RD_NEXT));
	wire        rd_last   = (state == S_RD_DATA) & fall & (bit_cnt == SESB_LAST_BIT);
	wire        rd_shift  = (state == S_RD_DATA) & fall & (bit_cnt != SESB_LAST_BIT);
	wire        wp_window = (state == S_DEVSEL) | (state == S_DEV_ACK) | (state == S_ADDR_HI)
		| (state == S_HI_ACK) | (state == S_ADDR_LO) | (state == S_LO_ACK);
	wire        wr_byte   = (state == S_WR_DATA) & rx_done & ~wp & quiet;
	// a stop counts only in the slot straight after a given data acknowledge
	wire        commit_ok = (state == S_WR_DATA) & data_acked;
	wire [14:0] addr_mask = SMALL_VARIANT ? SESB_MASK_SMALL : SESB_MASK_LARGE;
	wire        commit_ph = busy_st & (busy_cnt < SESB_BUSY_CNT_W'(SESB_PAGE_BYTES));
	wire [5:0]  commit_ix = busy_cnt[SESB_PAGE_W-1:0];
	wire        busy_done = busy_st
		& (busy_cnt == SESB_BUSY_CNT_W'(WRITE_TIME_CYCLES - 1));

	assign sda_out     = 1'b0;
	assign sda_oe      = oe;
	assign mem_rd_addr = addr;
	assign busy        = busy_st;

	// ===========================================================
	// next state
	always_comb begin
		next_state = state;
		if (busy_st) begin
			if (busy_done) begin
				next_state = S_IDLE;
			end
		end else if (start_ev) begin
			next_state = S_DEVSEL;
		end else if (stop_ev) begin
			// nack then stop, or any stray stop, lands in standby
			next_state = commit_ok ? S_BUSY : S_IDLE;
		end else begin
			unique case (state)
				S_IDLE, S_BUSY: next_state = state;
				S_DEVSEL: if (rx_done) begin
					next_state = dev_match ? S_DEV_ACK : S_IDLE;
				end
				S_DEV_ACK: if (fall) begin
					next_state = rd_mode ? S_RD_DATA : S_ADDR_HI;
				end
				S_ADDR_HI: if (rx_done) begin
					next_state = S_HI_ACK;
				end
				S_HI_ACK: if (fall) begin
					next_state = S_ADDR_LO;
				end
				S_ADDR_LO: if (rx_done) begin
					next_state = S_LO_ACK;
				end
				S_LO_ACK: if (fall) begin
					next_state = S_WR_DATA;
				end
				S_WR_DATA: if (rx_done) begin
					next_state = S_DATA_ACK;
				end
				S_DATA_ACK: if (fall) begin
					next_state = S_WR_DATA;
				end
				S_RD_DATA: if (rd_last) begin
					next_state = S_RD_ACK;
				end
				S_RD_ACK: if (ln.scl_rise) begin
					// master nack ends the read, ack asks for the next byte
					next_state = ln.sda ? S_IDLE : S_RD_NEXT;
				end
				S_RD_NEXT: if (fall) begin
					next_state = S_RD_DATA;
				end
			endcase
		end
	end

	// ===========================================================
	// data pin drive: set only on scl fall, so setup to the next rise is a full low phase; start, stop and busy release it at once
	always_comb begin
		next_oe = oe;
		if (busy_st | start_ev | stop_ev) begin
			next_oe = 1'b0;
		end else if (rx_done) begin
			if (state == S_DEVSEL) begin
				next_oe = dev_match;
			end else if (state == S_WR_DATA) begin
				next_oe = ~wp;
			end else begin
				next_oe = 1'b1;
			end
		end else if (load_rd) begin
			next_oe = ~mem_rd_data[7];
		end else if (rd_shift) begin
			next_oe = ~shreg[6];
		end else if (ack_end | rd_last) begin
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			oe    <= 1'b0;
		end else begin
			state <= next_state;
			oe    <= next_oe;
		end
	end

	// ===========================================================
	// shift register and bit counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shreg <= 8'h00;
		end else if (rx_bit) begin
			shreg <= {shreg[6:0], ln.sda};
		end else if (load_rd) begin
			shreg <= mem_rd_data;
		end else if (rd_shift) begin
			shreg <= {shreg[6:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bit_cnt <= 3'h0;
			rx_full <= 1'b0;
		end else if (start_ev | stop_ev | rx_done | load_rd) begin
			bit_cnt <= 3'h0;
			rx_full <= 1'b0;
		end else if (rx_bit | rd_shift) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_full <= rx_bit & (bit_cnt == SESB_LAST_BIT);
		end
	end

	// ===========================================================
	// direction, inhibit capture and acknowledge slot tracking
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_mode <= 1'b0;
		end else if ((state == S_DEVSEL) & rx_done) begin
			rd_mode <= shreg[SESB_RW_BIT];
		end
	end

	// inhibit seen at any point from start to the end of the low address acknowledge slot sticks
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wp <= 1'b0;
		end else if (start_ev) begin
			wp <= ln.wp;
		end else if (wp_window) begin
			wp <= wp | ln.wp;
		end
	end

	// cleared on the first fall of the next byte; the clock rise before a stop leaves it set
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			data_acked <= 1'b0;
		end else if ((state == S_DATA_ACK) & fall & oe) begin
			data_acked <= 1'b1;
		end else if (start_ev | ((state == S_WR_DATA) & fall)) begin
			data_acked <= 1'b0;
		end
	end

	// ===========================================================
	// address counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr <= SESB_ADDR_RST;
		end else if ((state == S_ADDR_HI) & rx_done & quiet) begin
			addr[14:8] <= shreg[6:0] & addr_mask[14:8];
		end else if ((state == S_ADDR_LO) & rx_done & quiet) begin
			addr[7:0] <= shreg;
		end else if (wr_byte) begin
			addr[5:0] <= addr[5:0] + SESB_PAGE_STEP;
		end else if (rd_last & quiet) begin
			addr <= (addr + SESB_ADDR_STEP) & addr_mask;
		end
	end

	// ===========================================================
	// page latch and self-timed commit
	always_ff @(posedge core_clk) begin
		if (wr_byte) begin
			page_buf[addr[5:0]] <= shreg;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			page_mask <= '0;
		end else if (start_ev) begin
			page_mask <= '0;
		end else if (wr_byte) begin
			page_mask[addr[5:0]] <= 1'b1;
		end
	end

	// first 64 busy cycles copy the latch out, the rest models the programming time
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_cnt <= '0;
		end else if (busy_st & ~busy_done) begin
			busy_cnt <= busy_cnt + SESB_BUSY_CNT_W'(1);
		end else begin
			busy_cnt <= '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_wr_en   <= 1'b0;
			mem_wr_addr <= SESB_ADDR_RST;
			mem_wr_data <= 8'h00;
		end else begin
			mem_wr_en   <= commit_ph & page_mask[commit_ix];
			mem_wr_addr <= {addr[14:6], commit_ix};
			mem_wr_data <= page_buf[commit_ix];
		end
	end

	// ===========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_devsel_done;
		(state == S_DEVSEL) && rx_done && quiet;
	endsequence

	sequence s_addr_byte_done;
		((state == S_ADDR_HI) || (state == S_ADDR_LO)) && rx_done && quiet;
	endsequence

	AST_DEV_ACK: assert property (s_devsel_done ##0 dev_match |=>
		sda_oe && (state == S_DEV_ACK)) else $error("matching select byte not acknowledged");
	AST_DEV_NACK: assert property (s_devsel_done ##0 !dev_match |=>
		!sda_oe && (state == S_IDLE)) else $error("mismatched select byte not released");
	AST_ADDR_ACK: assert property (s_addr_byte_done |=> sda_oe)
		else $error("address byte not acknowledged");
	AST_ADDR_RELEASE: assert property (((state == S_HI_ACK) || (state == S_LO_ACK))
		&& fall && quiet |=> !sda_oe ##1 !sda_oe) else $error("address acknowledge stuck");
	AST_WP_NACK: assert property ((state == S_WR_DATA) && rx_done && wp && quiet |=>
		!sda_oe && $stable(page_mask)) else $error("inhibited data byte taken");
	AST_ROW_WRAP: assert property (wr_byte |=> (addr[14:6] == $past(addr[14:6]))
		&& (addr[5:0] == 6'($past(addr[5:0]) + 6'h01))) else $error("bad page counter step");
	AST_COMMIT: assert property (stop_ev && commit_ok |=> busy)
		else $error("stop after data acknowledge did not start programming");
	AST_NO_COMMIT: assert property (stop_ev && !commit_ok |=> !busy)
		else $error("stray stop started programming");
	AST_BUSY_DEAF: assert property (busy && !busy_done |=> busy && !sda_oe)
		else $error("device answered or left busy early");
	AST_RD_STEP: assert property (rd_last && quiet |=>
		addr == 15'(($past(addr) + 15'h0001) & addr_mask)) else $error("read step missed");

endmodule : sesb_top

// *** sesb_top_tb.sv ***
// sesb_top_tb: self-checking bench of the serial eeprom bus slave with a byte array model.
// assumes the master model drives the bus; the array answers reads one cycle after the address.
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module sesb_top_tb
	import sesb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int         WT      = 100;
	// type code value is arbitrary
	localparam logic [3:0] TYPE_ID = 4'h6;

	logic                   core_clk = 1'b0;
	logic                   rst      = 1'b1;
	logic                   wip      = 1'b0;
	logic                   scl;
	logic                   m_low;
	wire logic              sda_line;
	logic                   sda_out;
	logic                   sda_oe;
	logic [SESB_ADDR_W-1:0] mem_rd_addr;
	logic [7:0]             mem_rd_data = 8'h00;
	logic                   mem_wr_en;
	logic [SESB_ADDR_W-1:0] mem_wr_addr;
	logic [7:0]             mem_wr_data;
	logic                   busy;
	logic [7:0]             mem [0:32767];
	int                     err_count = 0;
	int                     checks    = 0;
	int                     busy_run  = 0;
	int                     busy_len  = 0;

	// ===========================================================
	// clock, wire and array
	initial begin
		forever #50 core_clk = ~core_clk;
	end

	// open drain: either party pulling low wins, the pull-up otherwise
	assign sda_line = !(m_low === 1'b1) && !(sda_oe === 1'b1 && sda_out === 1'b0);

	function automatic logic [7:0] pat(input logic [14:0] a);
		return a[7:0] ^ 8'h3c;
	endfunction : pat

	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = pat(15'(i));
		end
	end

	always @(posedge core_clk) begin
		mem_rd_data <= mem[mem_rd_addr];
		if (mem_wr_en === 1'b1) begin
			mem[mem_wr_addr] <= mem_wr_data;
		end
		busy_run <= (busy === 1'b1) ? busy_run + 1 : 0;
		if (busy === 1'b0 && busy_run != 0) begin
			busy_len <= busy_run;
		end
	end

	sesb_master_model m (
		.core_clk (core_clk),
		.scl      (scl),
		.sda_low  (m_low),
		.sda_line (sda_line)
	);

	sesb_top #(
		.WRITE_TIME_CYCLES (WT),
		.SMALL_VARIANT     (1'b0),
		.DEV_TYPE_ID       (TYPE_ID)
	) dut (
		.core_clk          (core_clk),
		.rst               (rst),
		.scl_in            (scl),
		.sda_in            (sda_line),
		.sda_out           (sda_out),
		.sda_oe            (sda_oe),
		.write_inhibit_pin (wip),
		.mem_rd_addr       (mem_rd_addr),
		.mem_rd_data       (mem_rd_data),
		.mem_wr_en         (mem_wr_en),
		.mem_wr_addr       (mem_wr_addr),
		.mem_wr_data       (mem_wr_data),
		.busy              (busy)
	);

	// ===========================================================
	// shared bus steps
	function automatic logic [7:0] sel(input logic rw);
		return {TYPE_ID, SESB_CHIP_SEL, rw};
	endfunction : sel

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic [7:0] rx;
		logic       a;
		m.byte_io(b, 1'b1, rx, a);
		ack = ~a;
	endtask : wr_byte

	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic a;
		m.byte_io(8'hff, last, d, a);
	endtask : rd_byte

	// high address byte goes first
	task automatic hdr(input logic [15:0] a, output logic [2:0] k);
		m.start();
		wr_byte(sel(1'b0), k[2]);
		wr_byte(a[15:8], k[1]);
		wr_byte(a[7:0], k[0]);
	endtask : hdr

	task automatic wait_idle();
		for (int n = 0; n < 500 && busy !== 1'b0; n++) begin
			@(negedge core_clk);
		end
		`CHK("busy_end", 1'b0, busy)
	endtask : wait_idle

	// ===========================================================
	// scenarios
	task automatic t_select();
		logic [7:0] bad [4];
		logic       k;
		bad = '{{TYPE_ID, 3'h1, 1'b0}, {TYPE_ID, 3'h4, 1'b1}, {TYPE_ID ^ 4'h8, 3'h0, 1'b0},
			{TYPE_ID ^ 4'h1, 3'h0, 1'b1}};
		for (int i = 0; i < 4; i++) begin
			m.start();
			wr_byte(bad[i], k);
			`CHK("bad_sel_ack", 1'b0, k)
			wr_byte(8'h00, k);
			`CHK("standby_ack", 1'b0, k)
			m.stop();
		end
	endtask : t_select

	task automatic t_byte_write();
		logic [2:0] k3;
		logic       k;
		logic [7:0] d;
		hdr(16'h1234, k3);
		`CHK("hdr_acks", 3'h7, k3)
		wr_byte(8'ha5, k);
		`CHK("data_ack", 1'b1, k)
		m.stop();
		`CHK("busy_on_stop", 1'b1, busy)
		m.start();
		wr_byte(sel(1'b0), k);
		`CHK("poll_nack", 1'b0, k)
		m.stop();
		k = 1'b0;
		for (int n = 0; n < 10 && k !== 1'b1; n++) begin
			m.start();
			wr_byte(sel(1'b0), k);
		end
		`CHK("poll_ack", 1'b1, k)
		`CHK("busy_len", WT, busy_len)
		`CHK("array_byte", 8'ha5, mem[15'h1234])
		wip = 1'b1;
		wr_byte(8'h92, k);
		wr_byte(8'h34, k);
		m.start();
		wr_byte(sel(1'b1), k);
		`CHK("rd_sel_ack", 1'b1, k)
		rd_byte(1'b1, d);
		m.stop();
		`CHK("random_read", 8'ha5, d)
		wip = 1'b0;
		m.start();
		wr_byte(sel(1'b1), k);
		rd_byte(1'b1, d);
		m.stop();
		`CHK("current_read", pat(15'h1235), d)
	endtask : t_byte_write

	task automatic t_page();
		logic [7:0] exp [64];
		logic [2:0] k3;
		logic       k;
		logic [7:0] d;
		int         acks;
		acks = 0;
		for (int j = 0; j < 64; j++) begin
			exp[j] = pat(15'h0440 + 15'(j));
		end
		hdr(16'h047e, k3);
		for (int i = 0; i < 66; i++) begin
			wr_byte(8'h10 + 8'(i), k);
			acks += (k === 1'b1);
			exp[(62 + i) % 64] = 8'h10 + 8'(i);
		end
		m.stop();
		`CHK("page_acks", 66, acks)
		wait_idle();
		hdr(16'h0440, k3);
		m.start();
		wr_byte(sel(1'b1), k);
		for (int j = 0; j < 64; j++) begin
			rd_byte(j == 63, d);
			`CHK("page_byte", exp[j], d)
		end
		m.stop();
		`CHK("next_row", pat(15'h0480), mem[15'h0480])
	endtask : t_page

	task automatic t_inhibit();
		logic [2:0] k3;
		logic       k;
		wip = 1'b1;
		hdr(16'h0100, k3);
		`CHK("inh_hdr_acks", 3'h7, k3)
		wip = 1'b0;
		wr_byte(8'h77, k);
		`CHK("inh_data_ack", 1'b0, k)
		m.stop();
		`CHK("inh_busy", 1'b0, busy)
		`CHK("inh_array", pat(15'h0100), mem[15'h0100])
	endtask : t_inhibit

	task automatic t_bad_stop();
		logic [2:0] k3;
		logic       r;
		hdr(16'h0200, k3);
		m.stop();
		`CHK("stop_after_addr", 1'b0, busy)
		hdr(16'h0200, k3);
		for (int i = 0; i < 4; i++) begin
			m.bit_io(1'b0, r);
		end
		m.stop();
		`CHK("stop_mid_byte", 1'b0, busy)
		`CHK("stop_array", pat(15'h0200), mem[15'h0200])
	endtask : t_bad_stop

	// ===========================================================
	// run control
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		m.wt(3);
		t_select();
		t_byte_write();
		t_page();
		t_inhibit();
		t_bad_stop();
		summarize();
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		summarize();
	end
endmodule : sesb_top_tb
